/* File: rtl/cms_clock_mode_select.sv */
// Clock mode select register, pin-mode decode, gain lock and CPU clock suspend
// ============================================================================
`timescale 1ns/1ns
module cms_clock_mode_select
  import cms_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  cms_wr_t            wr,
  input  wire logic [15:0]   rd_addr,
  output logic [7:0]         rd_data,
  input  wire logic          sub_osc_start_bit,
  input  wire logic          ls_stop_req,
  input  wire logic          ls_sw_stop_allowed,
  input  cms_cpu_src_t       cpu_src_req,
  input  wire logic          stop_exit,
  input  wire logic          stab_done,
  input  wire logic          ext_clk_pin,
  output cms_pin_mode_t      main_pin_mode,
  output cms_pin_mode_t      sub_pin_mode,
  output cms_cpu_src_t       cpu_src,
  output logic               cpu_clk_suspend,
  output cms_ls_ticks_t      ls_ticks,
  output logic               ls_running
);

  // ==========================================================================
  // Decode helper used for both pin pairs
  function automatic cms_pin_mode_t pin_decode(input logic ext, input logic osc);
    case ({ext, osc})
      2'b01:   pin_decode = CMS_PIN_OSC;
      2'b11:   pin_decode = CMS_PIN_EXT;
      default: pin_decode = CMS_PIN_PORT;
    endcase
  endfunction

  logic [7:0]      reg_q, reg_d;
  logic            gain_used_q, gain_used_d;
  cms_susp_state_t st_q, st_d;
  logic [10:0]     cnt_q, cnt_d;
  logic [7:0]      ext_cnt_q, ext_cnt_d;
  logic [2:0]      ext_sync_q, ext_sync_d;
  logic            ext_lvl_q, ext_lvl_d;
  logic            ext_rise;
  logic            susp_q, susp_d;
  logic [7:0]      rd_q, rd_d;
  cms_pin_mode_t   main_q, main_d, sub_q, sub_d;
  cms_cpu_src_t    src_q, src_d;
  logic            wr_hit;
  logic [7:0]      merged;
  logic            gain_rise;

  // ==========================================================================
  // Register write with one-shot gain bit
  always_comb begin
    wr_hit      = wr.wr && (wr.addr == CMS_MODE_SEL_ADDR);
    merged      = (reg_q & ~wr.wbit_en) | (wr.wdata & wr.wbit_en);
    reg_d       = reg_q;
    gain_used_d = gain_used_q;
    if (wr_hit) begin
      reg_d = merged & CMS_MODE_SEL_WMASK;
      if (gain_used_q) begin
        reg_d[CMS_GAIN_BIT] = reg_q[CMS_GAIN_BIT];
      end else if (merged[CMS_GAIN_BIT] != reg_q[CMS_GAIN_BIT]) begin
        gain_used_d = 1'b1;
      end
    end
    gain_rise = wr_hit && !gain_used_q && merged[CMS_GAIN_BIT] && !reg_q[CMS_GAIN_BIT];
    rd_d      = (rd_addr == CMS_MODE_SEL_ADDR) ? reg_q : 8'h00;
  end

  // ==========================================================================
  // Pin modes and CPU source; low-speed clock takes no register bit and is instanced at the end of this module
  always_comb begin
    main_d = pin_decode(reg_q[CMS_MAIN_EXT_BIT], reg_q[CMS_MAIN_OSC_BIT]);
    if (sub_osc_start_bit) begin
      sub_d = CMS_PIN_OSC;
    end else begin
      sub_d = pin_decode(reg_q[CMS_SUB_EXT_BIT], reg_q[CMS_SUB_OSC_BIT]);
    end
    src_d = cpu_src_req;
  end

  // ==========================================================================
  // External clock edge detect on third and second stage only
  always_comb begin
    ext_sync_d = {ext_sync_q[1:0], ext_clk_pin};
    ext_lvl_d = ext_lvl_q;
    if (ext_sync_q[1] == ext_sync_q[2]) begin
      ext_lvl_d = ext_sync_q[2];
    end
    ext_rise = ext_lvl_d && !ext_lvl_q;
  end

  // ==========================================================================
  // Suspend sequencer
  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    ext_cnt_d = ext_cnt_q;
    case (st_q)
      CMS_SUSP_IDLE: begin
        cnt_d     = 11'h000;
        ext_cnt_d = 8'h00;
        if (gain_rise && src_q == CMS_CPU_XTAL) begin
          st_d = CMS_SUSP_TIME;
        end else if (gain_rise && src_q == CMS_CPU_EXT) begin
          st_d = CMS_SUSP_EXT;
        end else if (stop_exit && reg_q[CMS_GAIN_BIT]) begin
          case (src_q)
            CMS_CPU_INT_HS: st_d = CMS_SUSP_TIME;
            CMS_CPU_EXT:    st_d = CMS_SUSP_EXT;
            CMS_CPU_XTAL:   st_d = CMS_SUSP_STAB;
            default:        st_d = CMS_SUSP_IDLE;
          endcase
        end
      end
      CMS_SUSP_TIME: begin
        cnt_d = cnt_q + 11'h001;
        if (cnt_q == 11'(CMS_SUSP_CYC - 1)) begin
          st_d = CMS_SUSP_IDLE;
        end
      end
      CMS_SUSP_EXT: begin
        if (ext_rise) begin
          ext_cnt_d = ext_cnt_q + 8'h01;
          if (ext_cnt_q == 8'(CMS_EXT_SUSP_EDGES - 1)) begin
            st_d = CMS_SUSP_IDLE;
          end
        end
      end
      CMS_SUSP_STAB: begin
        if (stab_done) begin
          st_d = CMS_SUSP_IDLE;
        end
      end
      default: st_d = CMS_SUSP_IDLE;
    endcase
    susp_d = (st_d != CMS_SUSP_IDLE);
  end

  // ==========================================================================
  // Register and one-shot state; the read port is registered for timing
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_q       <= CMS_MODE_SEL_RESET;
      gain_used_q <= 1'b0;
      rd_q        <= 8'h00;
    end else begin
      reg_q       <= reg_d;
      gain_used_q <= gain_used_d;
      rd_q        <= rd_d;
    end
  end

  // ==========================================================================
  // Pin mode outputs one cycle behind the register, CPU source one cycle behind cpu_src_req
  always_ff @(posedge clk) begin
    if (reset) begin
      main_q <= CMS_PIN_PORT;
      sub_q  <= CMS_PIN_PORT;
      src_q  <= CMS_CPU_INT_HS;
    end else begin
      main_q <= main_d;
      sub_q  <= sub_d;
      src_q  <= src_d;
    end
  end

  // ==========================================================================
  // Pin synchroniser; level starts low like the idle pin, so no false edge
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_sync_q <= 3'h0;
      ext_lvl_q  <= 1'b0;
    end else begin
      ext_sync_q <= ext_sync_d;
      ext_lvl_q  <= ext_lvl_d;
    end
  end

  // ==========================================================================
  // Suspend sequencer state; counters clear in idle so each pause starts fresh
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q      <= CMS_SUSP_IDLE;
      cnt_q     <= 11'h000;
      ext_cnt_q <= 8'h00;
      susp_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      ext_cnt_q <= ext_cnt_d;
      susp_q    <= susp_d;
    end
  end

  // Low-speed oscillator and its tick fan-out
  cms_low_speed_osc u_ls_osc (
    .clk             (clk),
    .reset           (reset),
    .stop_req        (ls_stop_req),
    .sw_stop_allowed (ls_sw_stop_allowed),
    .ticks           (ls_ticks),
    .running         (ls_running)
  );

  assign rd_data         = rd_q;
  assign main_pin_mode   = main_q;
  assign sub_pin_mode    = sub_q;
  assign cpu_src         = src_q;
  assign cpu_clk_suspend = susp_q;

endmodule // cms_clock_mode_select

/* File: rtl/cms_pkg.sv */
// Package: constants and carriers for the clock mode select control block
package cms_pkg;

  // ==========================================================================
  // Register map
  localparam logic [15:0] CMS_MODE_SEL_ADDR  = 16'hff9f;
  localparam logic [7:0]  CMS_MODE_SEL_RESET = 8'h00;
  localparam logic [7:0]  CMS_MODE_SEL_WMASK = 8'hf1;  // Bits 3..1 reserved

  // ==========================================================================
  // Field positions
  localparam int CMS_MAIN_EXT_BIT = 7;
  localparam int CMS_MAIN_OSC_BIT = 6;
  localparam int CMS_SUB_EXT_BIT  = 5;
  localparam int CMS_SUB_OSC_BIT  = 4;
  localparam int CMS_GAIN_BIT     = 0;

  // ==========================================================================
  // Timing
  localparam int CMS_CLK_MHZ       = 100;
  localparam int CMS_SUSP_MIN_NS   = 4060;   // 4.06 us
  localparam int CMS_SUSP_MAX_NS   = 16120;  // 16.12 us
  // Aim at the least figure, rounded up to whole cycles
  localparam int CMS_SUSP_CYC      = (CMS_SUSP_MIN_NS * CMS_CLK_MHZ + 999) / 1000;
  localparam int CMS_EXT_SUSP_EDGES = 160;
  localparam int CMS_LS_FREQ_KHZ   = 240;
  // Low-speed tick period in system cycles, rounded down
  localparam int CMS_LS_DIV        = (CMS_CLK_MHZ * 1000) / CMS_LS_FREQ_KHZ;
  localparam int CMS_LS_DIV128     = 128;
  localparam int CMS_LS_DIV512     = 512;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    CMS_PIN_PORT = 2'b00,
    CMS_PIN_OSC  = 2'b01,
    CMS_PIN_EXT  = 2'b10
  } cms_pin_mode_t;

  typedef enum logic [1:0] {
    CMS_SUSP_IDLE = 2'b00,
    CMS_SUSP_TIME = 2'b01,
    CMS_SUSP_EXT  = 2'b10,
    CMS_SUSP_STAB = 2'b11
  } cms_susp_state_t;

  typedef enum logic [1:0] {
    CMS_CPU_INT_HS = 2'b00,
    CMS_CPU_XTAL   = 2'b01,
    CMS_CPU_EXT    = 2'b10,
    CMS_CPU_SUB    = 2'b11
  } cms_cpu_src_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  wbit_en;   // Bit-manipulation lanes, all ones for byte write
    logic        wr;
  } cms_wr_t;

  typedef struct packed {
    logic wdt_tick;
    logic h1_tick_div1;
    logic h1_tick_div128;
    logic h1_tick_div512;
  } cms_ls_ticks_t;

endpackage : cms_pkg

/* File: rtl/cms_low_speed_osc.sv */
// Low-speed oscillator model: tick source for watchdog and timer H1
`timescale 1ns/1ns
module cms_low_speed_osc
  import cms_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          stop_req,
  input  wire logic          sw_stop_allowed,
  output cms_ls_ticks_t      ticks,
  output logic               running
);

  logic [8:0]  div_q, div_d;
  logic [8:0]  pre_q, pre_d;
  logic        run_q, run_d;
  cms_ls_ticks_t ticks_q, ticks_d;
  logic        base;

  // ==========================================================================
  // Divider: starts on reset release with no software help
  always_comb begin
    run_d   = !(stop_req && sw_stop_allowed);
    base    = run_q && (div_q == 9'(CMS_LS_DIV - 1));
    div_d   = (!run_q || base) ? 9'h000 : div_q + 9'h001;
    pre_d   = base ? pre_q + 9'h001 : pre_q;
    ticks_d.wdt_tick       = base;
    ticks_d.h1_tick_div1   = base;
    ticks_d.h1_tick_div128 = base && (pre_q[6:0] == 7'(CMS_LS_DIV128 - 1));
    ticks_d.h1_tick_div512 = base && (pre_q == 9'(CMS_LS_DIV512 - 1));
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (reset) begin
      div_q   <= 9'h000;
      pre_q   <= 9'h000;
      run_q   <= 1'b1;
      ticks_q <= '0;
    end else begin
      div_q   <= div_d;
      pre_q   <= pre_d;
      run_q   <= run_d;
      ticks_q <= ticks_d;
    end
  end

  assign ticks   = ticks_q;
  assign running = run_q;

endmodule // cms_low_speed_osc

/* File: bench/cms_checker_assertions.sv */
// Checker: port-level properties of the clock mode select block
`timescale 1ns/1ns
module cms_checker
  import cms_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input cms_wr_t          wr,
  input wire logic [15:0] rd_addr,
  input wire logic [7:0]  rd_data,
  input wire logic        ls_sw_stop_allowed,
  input cms_cpu_src_t     cpu_src,
  input cms_pin_mode_t    main_pin_mode,
  input cms_pin_mode_t    sub_pin_mode,
  input wire logic        cpu_clk_suspend,
  input wire logic        ls_running
);
  // ==========================================================================
  // Helper state
  logic        gain_q, gain_d, lock_q, lock_d, chg;
  logic [15:0] cnt_q, cnt_d;
  assign chg = wr.wr && wr.addr == CMS_MODE_SEL_ADDR && wr.wbit_en[0] && wr.wdata[0] != gain_q;
  // Shadow gain with its one-shot lock; count suspended cycles
  always_comb begin
    gain_d = gain_q;
    lock_d = lock_q | chg;
    if (chg && !lock_q) begin
      gain_d = wr.wdata[0];
    end
    cnt_d = cpu_clk_suspend ? cnt_q + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk) begin
    gain_q <= reset ? 1'b0 : gain_d;
    lock_q <= reset ? 1'b0 : lock_d;
    cnt_q  <= reset ? 16'h0 : cnt_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================================================
  // Properties
  property p_rst; $fell(reset) |-> main_pin_mode == CMS_PIN_PORT && sub_pin_mode == CMS_PIN_PORT
    && !cpu_clk_suspend && ls_running; endproperty
  a_rst: assert property (p_rst) else $error("state after reset");
  property p_susp; chg && !lock_q && wr.wdata[0] && cpu_src == CMS_CPU_XTAL |=> cpu_clk_suspend; endproperty
  a_susp: assert property (p_susp) else $error("no suspend on gain set");
  property p_max; cpu_clk_suspend && cpu_src == CMS_CPU_INT_HS
    |-> cnt_q < 16'(CMS_SUSP_MAX_NS * CMS_CLK_MHZ / 1000); endproperty
  a_max: assert property (p_max) else $error("suspend too long");
  property p_min; $fell(cpu_clk_suspend) && cpu_src == CMS_CPU_INT_HS
    |-> cnt_q >= 16'(CMS_SUSP_MIN_NS * CMS_CLK_MHZ / 1000); endproperty
  a_min: assert property (p_min) else $error("suspend too short");
  property p_rsv; rd_data[3:1] == 3'b000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_unm; rd_addr != CMS_MODE_SEL_ADDR |=> rd_data == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_gain; rd_addr == CMS_MODE_SEL_ADDR |=> rd_data[0] == $past(gain_q); endproperty
  a_gain: assert property (p_gain) else $error("gain bit value");
  property p_ls; (!ls_sw_stop_allowed) [*2] |-> ls_running; endproperty
  a_ls: assert property (p_ls) else $error("low-speed clock stopped");
endmodule // cms_checker
bind cms_clock_mode_select cms_checker chk (.clk, .reset, .wr, .rd_addr, .rd_data, .ls_sw_stop_allowed,
  .cpu_src, .main_pin_mode, .sub_pin_mode, .cpu_clk_suspend, .ls_running);

/* File: bench/cms_ext_clk_src.sv */
// Partner: external high-speed clock source on the clock pin
`timescale 1ns/1ns
module cms_ext_clk_src #(
  parameter int HALF_NS = 25
) (
  input  wire logic en,
  output logic      ext_clk
);
  // Runs at 20 MHz only while the pin is an external input, else stands low
  initial begin
    ext_clk = 1'b0;
    // Offset keeps pin edges away from the sampling clock edge
    #2;
    forever begin
      #HALF_NS;
      ext_clk = en ? ~ext_clk : 1'b0;
    end
  end
endmodule // cms_ext_clk_src

/* File: bench/cms_clock_mode_select_test.sv */
// Testbench: self-checking run of the clock mode select block
`timescale 1ns/1ns
module cms_clock_mode_select_test import cms_pkg::*;;
  logic          clk, reset, sub_osc_start_bit, ls_stop_req, ls_sw_stop_allowed;
  logic          stop_exit, stab_done, ext_clk_pin, cpu_clk_suspend, ls_running;
  cms_wr_t       wr;
  logic [15:0]   rd_addr;
  logic [7:0]    rd_data;
  cms_cpu_src_t  cpu_src_req, cpu_src;
  cms_pin_mode_t main_pin_mode, sub_pin_mode;
  cms_ls_ticks_t ls_ticks;
  int            miscompares, checks_done, n;
  cms_pin_mode_t mexp [4] = '{CMS_PIN_PORT, CMS_PIN_OSC, CMS_PIN_PORT, CMS_PIN_EXT};
  cms_clock_mode_select dut (.clk, .reset, .wr, .rd_addr, .rd_data, .sub_osc_start_bit, .ls_stop_req,
    .ls_sw_stop_allowed, .cpu_src_req, .stop_exit, .stab_done, .ext_clk_pin, .main_pin_mode,
    .sub_pin_mode, .cpu_src, .cpu_clk_suspend, .ls_ticks, .ls_running);
  cms_ext_clk_src src (.en(main_pin_mode === CMS_PIN_EXT), .ext_clk(ext_clk_pin));
  // ==========================================================================
  // Shared tasks; inputs move 1 ns after the edge so no race with the design
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk) #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end
    else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic do_reset();
    reset = 1'b1;
    tick(10);
    reset = 1'b0;
  endtask
  task automatic wr_reg(logic [7:0] d, logic [7:0] en);
    tick(1);
    wr = '{CMS_MODE_SEL_ADDR, d, en, 1'b1};
    tick(1);
    wr.wr = 1'b0;
  endtask
  // Counts suspended cycles; a hang past the bound ends the run
  task automatic susp_len(output int k);
    logic seen;
    seen = 1'b0;
    k = 0;
    repeat (3000) begin
      if (cpu_clk_suspend === 1'b1) begin
        seen = 1'b1;
        k++;
      end
      else if (seen) return;
      tick(1);
    end
    miscompares++;
    wrap_up();
  endtask
  // Waits for a watchdog tick; running out of the bound ends the run
  task automatic wait_tick(output int k);
    k = 0;
    while (ls_ticks.wdt_tick !== 1'b1) begin
      if (k == 1000) begin
        miscompares++;
        wrap_up();
      end
      tick(1);
      k++;
    end
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_rst();
    chk("reg", rd_data, 8'h00);
    chk("modes", {main_pin_mode, sub_pin_mode, cpu_clk_suspend}, 5'h00);
    chk("ls_running", ls_running, 1'b1);
    rd_addr = 16'hff9e;
    tick(2);
    chk("unmapped", rd_data, 8'h00);
    rd_addr = CMS_MODE_SEL_ADDR;
  endtask
  // CPU stays on the internal clock while the main pin is set to port, oscillator and external input
  task automatic t_modes();
    for (int i = 0; i < 8; i++) begin
      sub_osc_start_bit = i[2];
      wr_reg({i[1:0], i[1:0], 4'h0}, 8'hff);
      tick(1);
      chk("main_mode", main_pin_mode, mexp[i[1:0]]);
      chk("sub_mode", sub_pin_mode, i[2] ? CMS_PIN_OSC : mexp[i[1:0]]);
    end
    wr_reg(8'h0e, 8'hff);
    tick(1);
    chk("reserved", rd_data, 8'h00);
  endtask
  task automatic t_gain();
    cpu_src_req = CMS_CPU_XTAL;
    tick(2);
    chk("cpu_src", cpu_src, CMS_CPU_XTAL);
    wr_reg(8'h01, 8'h01);
    susp_len(n);
    chk("xtal_susp", n >= 406 && n <= 1612, 1'b1);
    wr_reg(8'h00, 8'h01);
    tick(1);
    chk("gain_lock", rd_data, 8'h01);
    wr_reg(8'h4e, 8'hff);
    tick(1);
    chk("byte_wr", rd_data, 8'h41);
    rd_addr = CMS_MODE_SEL_ADDR - 16'h0001;
    tick(2);
    chk("unmapped_set", rd_data, 8'h00);
    rd_addr = CMS_MODE_SEL_ADDR;
  endtask
  task automatic t_stop();
    for (int i = 0; i < 2; i++) begin
      cpu_src_req = i ? CMS_CPU_XTAL : CMS_CPU_INT_HS;
      tick(2);
      stop_exit = 1'b1;
      tick(1);
      stop_exit = 1'b0;
      tick(20 * i);
      chk("stop_held", cpu_clk_suspend, 1'b1);
      stab_done = i[0];
      susp_len(n);
      stab_done = 1'b0;
      chk("stop_susp", i ? n < 4 : n >= 406 && n <= 1612, 1'b1);
    end
  endtask
  // Gain is set after reset once the main pin has been made an external input
  task automatic t_ext();
    do_reset();
    cpu_src_req = CMS_CPU_EXT;
    tick(1);
    chk("reg_cleared", rd_data, 8'h00);
    wr_reg(8'hc0, 8'hff);
    tick(4);
    wr_reg(8'h01, 8'h01);
    susp_len(n);
    chk("ext_susp", n >= 796 && n <= 812, 1'b1);
    stop_exit = 1'b1;
    tick(1);
    stop_exit = 1'b0;
    susp_len(n);
    chk("ext_stop_susp", n >= 796 && n <= 812, 1'b1);
  endtask
  // Fresh reset so the /128 tick lands on the 128th watchdog tick
  task automatic t_div();
    int cnt;
    cnt = 0;
    do_reset();
    while (cnt < CMS_LS_DIV128 + 1) begin
      wait_tick(n);
      cnt++;
      chk("h1_div1", ls_ticks.h1_tick_div1, 1'b1);
      if (ls_ticks.h1_tick_div128 === 1'b1) begin
        break;
      end
      tick(1);
    end
    chk("h1_div128", cnt, CMS_LS_DIV128);
    chk("h1_div512", ls_ticks.h1_tick_div512, 1'b0);
  endtask
  task automatic t_ls();
    ls_stop_req = 1'b1;
    tick(4);
    chk("ls_kept", ls_running, 1'b1);
    wait_tick(n);
    tick(1);
    wait_tick(n);
    chk("ls_gap", n, CMS_LS_DIV - 1);
    ls_sw_stop_allowed = 1'b1;
    tick(4);
    chk("ls_stop", ls_running, 1'b0);
  endtask
  // Main sequence
  initial begin
    {reset, sub_osc_start_bit, ls_stop_req, ls_sw_stop_allowed, stop_exit, stab_done} = '0;
    wr = '0;
    rd_addr = CMS_MODE_SEL_ADDR;
    cpu_src_req = CMS_CPU_INT_HS;
    miscompares = 0;
    checks_done = 0;
    do_reset();
    t_rst();
    t_modes();
    t_gain();
    t_stop();
    t_ext();
    t_div();
    t_ls();
    wrap_up();
  end
endmodule // cms_clock_mode_select_test
